// ==== rtl/tmcd_pkg.sv ====
// Purpose: Constants for the timer mode configuration decoder
// Assumes: 32-bit Avalon-MM register window, word addressed by byte offset
// Notes: Offsets are local to this block
package tmcd_pkg;
   localparam int TMCD_ADDR_W = 4;
   localparam logic [3:0] TMCD_OFS_MODE = 4'h0;
   localparam logic [3:0] TMCD_OFS_CTRL = 4'h4;
   localparam logic [3:0] TMCD_OFS_STAT = 4'h8;
   localparam logic [7:0] TMCD_MODE_RST = 8'h00;
   localparam logic [7:0] TMCD_CTRL_RST = 8'h00;
   localparam int TMCD_T1_MODE_HI = 5;
   localparam int TMCD_T1_MODE_LO = 4;
   localparam int TMCD_T0_GATE_BIT = 3;
   localparam int TMCD_T0_SRC_BIT = 2;
   localparam int TMCD_T0_MODE_HI = 1;
   localparam int TMCD_T0_MODE_LO = 0;
   localparam int TMCD_CTRL_RUN0_BIT = 0;
   localparam int TMCD_CTRL_PRE0_BIT = 1;
   localparam int TMCD_CTRL_SRC1_BIT = 2;
   localparam int TMCD_CTRL_RUN1_BIT = 3;
   typedef enum logic [1:0] {
      TMCD_M13 = 2'h0,
      TMCD_M16 = 2'h1,
      TMCD_M8AR = 2'h2,
      TMCD_MSPLIT = 2'h3
   } tmcd_mode_t;
endpackage

// ==== rtl/tmcd_top.sv ====
// Purpose: Decode timer 0/1 mode, gate and source configuration into count controls
// Assumes: Avalon-MM slave with waitrequest, clk_sys 100 MHz, synchronous active-high reset
// Notes: Counter datapaths live elsewhere; this block issues mode decodes and count strobes
////////////////////////////////////////////////////////////////////////////////
module tmcd_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [tmcd_pkg::TMCD_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic tick_sysclk,
   input wire logic tick_prescaled,
   input wire logic timer0_count_pin,
   input wire logic timer1_count_pin,
   input wire logic ext_interrupt0_pin,
   output logic [1:0] timer0_mode_q,
   output logic [1:0] timer1_mode_q,
   output logic timer0_inc_q,
   output logic timer1_inc_q,
   output logic timer1_stopped_q,
   output logic timer0_split_q
);
   import tmcd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers and bus
   logic [7:0] mode_reg_q;
   logic [7:0] mode_reg_d;
   logic [7:0] ctrl_reg_q;
   logic [7:0] ctrl_reg_d;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_next;
   logic req;
   logic sel_mode;
   logic sel_ctrl;
   logic sel_stat;
   logic wr_mode;
   logic wr_ctrl;
   logic [7:0] stat_word;

   // One wait cycle then acknowledge
   assign req = (avs_read | avs_write) & ~ack_q;
   assign sel_mode = (avs_address == TMCD_OFS_MODE);
   assign sel_ctrl = (avs_address == TMCD_OFS_CTRL);
   assign sel_stat = (avs_address == TMCD_OFS_STAT);
   assign wr_mode = req & avs_write & sel_mode & avs_byteenable[0];
   assign wr_ctrl = req & avs_write & sel_ctrl & avs_byteenable[0];
   assign mode_reg_d = wr_mode ? avs_writedata[7:0] : mode_reg_q;
   assign ctrl_reg_d = wr_ctrl ? avs_writedata[7:0] : ctrl_reg_q;
   assign rdata_d = sel_mode ? {24'h000000, mode_reg_q} :
                    sel_ctrl ? {24'h000000, ctrl_reg_q} :
                    sel_stat ? {24'h000000, stat_word} : 32'h00000000;
   assign rdata_next = req ? rdata_d : rdata_q;

   // Mode register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode_reg_q <= TMCD_MODE_RST;
      end
      else begin
         mode_reg_q <= mode_reg_d;
      end
   end

   // Control register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_reg_q <= TMCD_CTRL_RST;
      end
      else begin
         ctrl_reg_q <= ctrl_reg_d;
      end
   end

   // Access flag, high in the answer cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_q <= 1'b0;
      end
      else begin
         ack_q <= req;
      end
   end

   // Wait request from its own flop, low in the answer cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end
      else begin
         avs_waitrequest <= ~req;
      end
   end

   // Read data captured when a request is taken
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_q <= 32'h00000000;
      end
      else begin
         rdata_q <= rdata_next;
      end
   end

   assign avs_readdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detect
   logic t0_meta_q;
   logic t0_sync_q;
   logic t0_prev_q;
   logic t1_meta_q;
   logic t1_sync_q;
   logic t1_prev_q;
   logic ext_interrupt0_pin_meta_q;
   logic ext_interrupt0_pin_sync_q;

   // Timer 0 count pin, first flop
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         t0_meta_q <= 1'b0;
      end
      else begin
         t0_meta_q <= timer0_count_pin;
      end
   end

   // Timer 0 count pin, second flop
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         t0_sync_q <= 1'b0;
      end
      else begin
         t0_sync_q <= t0_meta_q;
      end
   end

   // Timer 0 count pin, previous sample for edge detect
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         t0_prev_q <= 1'b0;
      end
      else begin
         t0_prev_q <= t0_sync_q;
      end
   end

   // Timer 1 count pin, first flop
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         t1_meta_q <= 1'b0;
      end
      else begin
         t1_meta_q <= timer1_count_pin;
      end
   end

   // Timer 1 count pin, second flop
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         t1_sync_q <= 1'b0;
      end
      else begin
         t1_sync_q <= t1_meta_q;
      end
   end

   // Timer 1 count pin, previous sample for edge detect
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         t1_prev_q <= 1'b0;
      end
      else begin
         t1_prev_q <= t1_sync_q;
      end
   end

   // Interrupt pin, first flop
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ext_interrupt0_pin_meta_q <= 1'b0;
      end
      else begin
         ext_interrupt0_pin_meta_q <= ext_interrupt0_pin;
      end
   end

   // Interrupt pin, second flop
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ext_interrupt0_pin_sync_q <= 1'b0;
      end
      else begin
         ext_interrupt0_pin_sync_q <= ext_interrupt0_pin_meta_q;
      end
   end

   logic t0_fall;
   logic t1_fall;
   logic ext_interrupt0_pin_lvl;
   assign t0_fall = t0_prev_q & ~t0_sync_q;
   assign t1_fall = t1_prev_q & ~t1_sync_q;
   assign ext_interrupt0_pin_lvl = ext_interrupt0_pin_sync_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Mode decode and count qualification
   logic timer0_gate_select;
   logic timer0_source_select;
   logic [1:0] timer0_mode_field;
   logic [1:0] timer1_mode_field;
   logic timer0_run_bit;
   logic timer0_prescale_select;
   logic timer1_source_select;
   logic timer1_run_bit;
   logic t0_enable;
   logic t0_tick;
   logic t1_tick;
   logic t0_inc_d;
   logic t1_inc_d;
   logic t1_stop_d;
   logic t0_split_d;

   assign timer0_gate_select = mode_reg_q[TMCD_T0_GATE_BIT];
   assign timer0_source_select = mode_reg_q[TMCD_T0_SRC_BIT];
   assign timer0_mode_field = mode_reg_q[TMCD_T0_MODE_HI:TMCD_T0_MODE_LO];
   assign timer1_mode_field = mode_reg_q[TMCD_T1_MODE_HI:TMCD_T1_MODE_LO];
   assign timer0_run_bit = ctrl_reg_q[TMCD_CTRL_RUN0_BIT];
   assign timer0_prescale_select = ctrl_reg_q[TMCD_CTRL_PRE0_BIT];
   assign timer1_source_select = ctrl_reg_q[TMCD_CTRL_SRC1_BIT];
   assign timer1_run_bit = ctrl_reg_q[TMCD_CTRL_RUN1_BIT];

   // Gate: run alone, or run and interrupt pin high
   assign t0_enable = timer0_run_bit & (~timer0_gate_select | ext_interrupt0_pin_lvl);
   // Source: internal timebase or falling edges on the count pin
   assign t0_tick = timer0_source_select ? t0_fall :
                    (timer0_prescale_select ? tick_sysclk : tick_prescaled);
   assign t1_tick = timer1_source_select ? t1_fall : tick_prescaled;
   assign t1_stop_d = (timer1_mode_field == TMCD_MSPLIT);
   assign t0_inc_d = t0_enable & t0_tick;
   assign t1_inc_d = timer1_run_bit & ~t1_stop_d & t1_tick;
   assign t0_split_d = (timer0_mode_field == TMCD_MSPLIT);
   assign stat_word = {2'h0, ext_interrupt0_pin_lvl, t0_enable, timer1_mode_field, timer0_mode_field};

   // Timer 0 mode output
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timer0_mode_q <= TMCD_M13;
      end
      else begin
         timer0_mode_q <= timer0_mode_field;
      end
   end

   // Timer 1 mode output
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timer1_mode_q <= TMCD_M13;
      end
      else begin
         timer1_mode_q <= timer1_mode_field;
      end
   end

   // Timer 0 increment pulse
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timer0_inc_q <= 1'b0;
      end
      else begin
         timer0_inc_q <= t0_inc_d;
      end
   end

   // Timer 1 increment pulse
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timer1_inc_q <= 1'b0;
      end
      else begin
         timer1_inc_q <= t1_inc_d;
      end
   end

   // Timer 1 stopped flag
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timer1_stopped_q <= 1'b0;
      end
      else begin
         timer1_stopped_q <= t1_stop_d;
      end
   end

   // Timer 0 split flag
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timer0_split_q <= 1'b0;
      end
      else begin
         timer0_split_q <= t0_split_d;
      end
   end

endmodule // tmcd_top

// ==== dv/tmcd_props.sv ====
// Purpose: Port assertions for tmcd_top
// Assumes: Shadow bytes follow accepted low-lane writes
// Notes: Bound to every tmcd_top
module tmcd_props_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic tick_sysclk,
   input wire logic timer0_count_pin,
   input wire logic timer1_count_pin,
   input wire logic ext_interrupt0_pin,
   input wire logic timer0_inc_q,
   input wire logic timer1_inc_q,
   input wire logic timer1_stopped_q,
   input wire logic timer0_split_q,
   input wire logic [tmcd_pkg::TMCD_ADDR_W-1:0] avs_address,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [1:0] timer0_mode_q,
   input wire logic [1:0] timer1_mode_q
);
   import tmcd_pkg::*;
   logic [7:0] m_q, c_q;
   wire acc = avs_write && !avs_waitrequest && avs_byteenable[0];
   always_ff @(posedge clk_sys) begin
      if (rst || (acc && avs_address == TMCD_OFS_MODE)) m_q <= rst ? TMCD_MODE_RST : avs_writedata[7:0];
      if (rst || (acc && avs_address == TMCD_OFS_CTRL)) c_q <= rst ? TMCD_CTRL_RST : avs_writedata[7:0];
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_fall0;
      $fell(timer0_count_pin) && m_q[2] && !m_q[3] && c_q[0];
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   chk_t1_stop_flag: assert property (timer1_stopped_q == (timer1_mode_q == 2'h3)) else $error("t1 stop");
   chk_t1_stop_hold: assert property (timer1_stopped_q [*4] |-> !timer1_inc_q) else $error("t1 held");
   chk_t1_mode_map: assert property ($stable(m_q) |-> timer1_mode_q == m_q[5:4]) else $error("t1 mode");
   chk_t0_mode_map: assert property ($stable(m_q) |-> timer0_mode_q == m_q[1:0]) else $error("t0 mode");
   chk_t0_split: assert property (timer0_split_q == (timer0_mode_q == 2'h3)) else $error("t0 split");
   chk_gate_closed: assert property ((m_q[3] && !ext_interrupt0_pin) [*8] |-> !timer0_inc_q)
      else $error("gate");
   chk_tick_count: assert property (m_q[3:2] == 2'h0 && c_q[1:0] == 2'h3 && tick_sysclk |-> ##[1:3] timer0_inc_q)
      else $error("tick");
   chk_pin_count0: assert property (s_fall0 |-> ##[3:4] timer0_inc_q) else $error("pin0");
   chk_one_count: assert property (timer0_inc_q && m_q[2] |=> !timer0_inc_q) else $error("twice");
   chk_pin_count1: assert property ($fell(timer1_count_pin) && c_q[3:2] == 2'h3 && m_q[5:4] != 2'h3
      |-> ##[3:4] timer1_inc_q) else $error("pin1");
endmodule // tmcd_props_chk
bind tmcd_top tmcd_props_chk tmcd_props_chk_inst (.*);

// ==== dv/timer_mode_config_decode_tb.sv ====
// Purpose: Self-checking bench for tmcd_top
// Assumes: Avalon master, 100 MHz clock
// Notes: Counts increment pulses per scenario
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module timer_mode_config_decode_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tmcd_pkg::*;
   logic clk_sys = 1'h0, rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0, tick_sysclk = 1'h0, tick_prescaled = 1'h0;
   logic timer0_count_pin = 1'h1, timer1_count_pin = 1'h1, ext_interrupt0_pin = 1'h0, avs_waitrequest, timer0_inc_q;
   logic timer1_inc_q, timer1_stopped_q, timer0_split_q;
   logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rdq;
   logic [1:0] timer0_mode_q, timer1_mode_q;
   int failures = 0, n_checks = 0, cyc = 0, c0 = 0, c1 = 0;
   tmcd_top tmcd_top_inst (.*);
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (timer0_inc_q === 1'h1) c0 <= c0 + 1;
      if (timer1_inc_q === 1'h1) c1 <= c1 + 1;
      if (cyc == 2000) begin
         failures++;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'h0) @(posedge clk_sys);
      rdq = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      @(posedge clk_sys);
   endtask
   task automatic cfg(input logic [7:0] m, input logic [7:0] c);
      bus(1'h1, TMCD_OFS_MODE, m, 4'hF);
      bus(1'h1, TMCD_OFS_CTRL, c, 4'hF);
      repeat (4) @(posedge clk_sys);
      c0 = 0;
      c1 = 0;
   endtask
   task automatic tick8(input logic sys);
      if (sys) tick_sysclk <= 1'h1;
      else tick_prescaled <= 1'h1;
      repeat (8) @(posedge clk_sys);
      tick_sysclk <= 1'h0;
      tick_prescaled <= 1'h0;
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic fall3(input logic t1);
      repeat (3) begin
         if (t1) timer1_count_pin <= 1'h0;
         else timer0_count_pin <= 1'h0;
         repeat (2) @(posedge clk_sys);
         timer0_count_pin <= 1'h1;
         timer1_count_pin <= 1'h1;
         repeat (2) @(posedge clk_sys);
      end
      repeat (6) @(posedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      bus(1'h1, TMCD_OFS_MODE, 8'hC5, 4'hE);
      bus(1'h0, TMCD_OFS_MODE, 8'h0, 4'hF);
      `CHK("mode_rst", {24'h0, TMCD_MODE_RST}, rdq)
      bus(1'h1, 4'hC, 8'h3A, 4'hF);
      bus(1'h0, 4'hC, 8'h0, 4'hF);
      `CHK("unmapped", 32'h0, rdq)
   endtask
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         cfg({2'h0, m[1:0], 2'h0, m[1:0]}, 8'h0);
         `CHK("t0_mode", m[1:0], timer0_mode_q)
         `CHK("t1_mode", m[1:0], timer1_mode_q)
         `CHK("split", m == 3, timer0_split_q)
         `CHK("stopped", m == 3, timer1_stopped_q)
      end
   endtask
   task automatic t_gate();
      cfg(8'h08, 8'h03);
      tick8(1'h1);
      `CHK("gated", 0, c0)
      ext_interrupt0_pin <= 1'h1;
      repeat (3) @(posedge clk_sys);
      tick8(1'h1);
      `CHK("gate_open", 8, c0)
      bus(1'h0, TMCD_OFS_STAT, 8'h0, 4'hF);
      `CHK("status", 32'h30, rdq)
      ext_interrupt0_pin <= 1'h0;
      cfg(8'h00, 8'h03);
      tick8(1'h1);
      `CHK("no_gate", 8, c0)
   endtask
   task automatic t_src();
      cfg(8'h00, 8'h01);
      tick8(1'h1);
      `CHK("pre_sys", 0, c0)
      tick8(1'h0);
      `CHK("pre_slow", 8, c0)
      cfg(8'h04, 8'h01);
      fall3(1'h0);
      `CHK("pin0", 3, c0)
      cfg(8'h00, 8'h0C);
      fall3(1'h1);
      `CHK("pin1", 3, c1)
      cfg(8'h30, 8'h0C);
      fall3(1'h1);
      `CHK("t1_stop", 0, c1)
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'h0;
      t_regs();
      t_modes();
      t_gate();
      t_src();
      end_sim();
   end
endmodule // timer_mode_config_decode_tb
